// ==== src/ext_irq_pkg.sv ====
package ext_irq_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int EXT_N = 3;
  localparam int PC_GROUPS = 4;
  localparam int PC_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_MCU_CONTROL = 8'h55;
  localparam logic [7:0] OFS_SENSE_CONTROL = 8'h69;
  localparam logic [7:0] OFS_EXT_MASK = 8'h3D;
  localparam logic [7:0] OFS_EXT_FLAG = 8'h3C;
  localparam logic [7:0] OFS_PC_CONTROL = 8'h68;
  localparam logic [7:0] OFS_PC_FLAG = 8'h3B;
  localparam logic [7:0] OFS_PC_MASK_BASE = 8'h6B;
  // Field positions in the control register
  localparam int BIT_VEC_SEL = 1;
  localparam int BIT_VEC_CE = 0;
  // Sense field position and width
  localparam int SENSE_W = 2;
  localparam int SENSE_LSB_0 = 0;
  localparam int SENSE_LSB_1 = 2;
  localparam int SENSE_LSB_2 = 4;
  // Sense encodings
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_ANY = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  // Guarded vector move window in cycles
  localparam int VEC_CE_CYCLES = 4;
  localparam logic [1:0] VEC_CE_LOAD = 2'(VEC_CE_CYCLES - 1);
endpackage

// ==== src/pin_sync_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync_edge #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pins
  input wire logic [W-1:0] pin,
  // Sampled level and edge pulses
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import ext_irq_pkg::*;

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // Refuse an empty pin vector at elaboration
  if (W < 1)
  begin : g_bad_width
    $error("pin_sync_edge: W must be at least 1");
  end

  // Two-stage chain then one stage of history
  always_comb
  begin
    st_d = st_q;
    st_d.meta = pin;
    st_d.sync = st_q.meta;
    st_d.prev = st_q.sync;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Single-cycle edge pulses from current versus previous sample
  assign level = st_q.sync;
  assign rise = st_q.sync & ~st_q.prev;
  assign fall = ~st_q.sync & st_q.prev;
endmodule
`default_nettype wire

// ==== src/external_irq_sense_vector_ctl.sv ====
// Function
// - vector select zero puts vectors at flash start, one at boot start.
// - interrupts blocked from change enable until after following instruction.
// - without a select write, interrupts stay blocked four cycles.
// - the automatic block never alters the global enable bit.
// - change enable self-clears after four cycles or on select write.
// - boot lock bits suppress interrupts in the section without vectors.
// - pins trigger interrupts even when driven as outputs.
// - any enabled toggle in a group of eight raises that group request.
// - four per-group masks choose which pins feed each group.
// - pin changes are seen asynchronously to wake from deep sleep.
// - low level mode keeps requesting while the pin stays low.
// - dedicated edges are recognised only while the clock runs.
// - low level on dedicated pins is seen asynchronously for wake.
// - a low level gone before start-up wakes without an interrupt.
// - a dedicated interrupt needs global enable and its own mask bit.
// - sense codes: 00 low, 01 any change, 10 falling, 11 rising.
// - pins are sampled before edge detection; longer pulses always count.
// - sense fields for interrupt 2 at bits 5:4, 1 at 3:2, reset zero.
// - sense field for interrupt 0 at bits 1:0, same encoding.
// - edge flag sets on trigger, clears on handler or write one.
// - mask register holds one enable per dedicated interrupt.
`timescale 1ns/1ps
`default_nettype none
module external_irq_sense_vector_ctl #(
  parameter logic [15:0] FLASH_WORDS = 16'h2000,
  parameter logic [15:0] BOOT_MIN_WORDS = 16'h0100
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [ext_irq_pkg::ADDR_W-1:0] io_addr,
  input wire logic [ext_irq_pkg::DATA_W-1:0] io_wdata,
  input wire logic io_we,
  input wire logic io_re,
  output logic [ext_irq_pkg::DATA_W-1:0] io_rdata,
  // Core context
  input wire logic global_irq_enable,
  input wire logic instr_done,
  input wire logic executing_boot,
  input wire logic app_side_boot_lock,
  input wire logic boot_side_boot_lock,
  input wire logic [1:0] boot_size_fuses,
  input wire logic [ext_irq_pkg::EXT_N-1:0] ext_ack,
  input wire logic [ext_irq_pkg::PC_GROUPS-1:0] pc_ack,
  // Pins
  input wire logic [ext_irq_pkg::EXT_N-1:0] ext_irq_pin,
  input wire logic [ext_irq_pkg::PC_GROUPS*ext_irq_pkg::PC_W-1:0]
    pin_change_input,
  // Requests and vector placement
  output logic [ext_irq_pkg::EXT_N-1:0] ext_irq_req,
  output logic [ext_irq_pkg::PC_GROUPS-1:0] pin_change_req,
  output logic vector_table_select,
  output logic [15:0] vector_base,
  output logic irq_blocked,
  output logic wake_req
);
  import ext_irq_pkg::*;

  localparam int PCN = PC_GROUPS * PC_W;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic vec_sel;
    logic vec_ce;
    logic [1:0] ce_cnt;
    logic post_blk;
    logic [5:0] sense;
    logic [EXT_N-1:0] emask;
    logic [EXT_N-1:0] eflag;
    logic [PC_GROUPS-1:0] pcie;
    logic [PC_GROUPS-1:0] pcflag;
    logic [PCN-1:0] pcmsk;
    logic [EXT_N-1:0] ereq;
    logic [PC_GROUPS-1:0] pcreq;
    logic blocked;
    logic [15:0] vbase;
  } ctl_s;

  ctl_s st_q;
  ctl_s st_d;
  logic [1:0] rst_sync_q;
  logic rst_i_n;
  logic [EXT_N-1:0] e_lvl;
  logic [EXT_N-1:0] e_rise;
  logic [EXT_N-1:0] e_fall;
  logic [PCN-1:0] p_lvl;
  logic [PCN-1:0] p_rise;
  logic [PCN-1:0] p_fall;
  logic [PC_GROUPS-1:0] pc_hit;
  logic [EXT_N-1:0] e_set;
  logic [EXT_N-1:0] e_low;
  logic mcu_wr;
  logic lock_sup;

  // Refuse boot sizes whose largest setting overruns flash
  if ((BOOT_MIN_WORDS << 3) > FLASH_WORDS || BOOT_MIN_WORDS == 16'h0000)
  begin : g_bad_boot
    $error("boot section sizes do not fit flash");
  end

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_i_n = rst_sync_q[1];

  pin_sync_edge #(.W(EXT_N)) u_ext_sync (
    .clk(clk),
    .rst_n(rst_i_n),
    .pin(ext_irq_pin),
    .level(e_lvl),
    .rise(e_rise),
    .fall(e_fall)
  );

  // Pin change inputs sampled the same way
  pin_sync_edge #(.W(PCN)) u_pc_sync (
    .clk(clk),
    .rst_n(rst_i_n),
    .pin(pin_change_input),
    .level(p_lvl),
    .rise(p_rise),
    .fall(p_fall)
  );

  // Per-bit trigger decode from the sense fields
  always_comb
  begin
    for (int i = 0; i < EXT_N; i++)
    begin
      e_low[i] = (st_q.sense[i*SENSE_W +: SENSE_W] == SENSE_LOW);
      case (st_q.sense[i*SENSE_W +: SENSE_W])
        SENSE_ANY: e_set[i] = e_rise[i] | e_fall[i];
        SENSE_FALL: e_set[i] = e_fall[i];
        SENSE_RISE: e_set[i] = e_rise[i];
        default: e_set[i] = 1'b0;
      endcase
    end
  end

  always_comb
  begin
    for (int g = 0; g < PC_GROUPS; g++)
    begin
      pc_hit[g] = |((p_rise[g*PC_W +: PC_W] | p_fall[g*PC_W +: PC_W])
        & st_q.pcmsk[g*PC_W +: PC_W]);
    end
  end

  assign mcu_wr = io_we && (io_addr == OFS_MCU_CONTROL);

  assign lock_sup = (st_q.vec_sel && app_side_boot_lock && !executing_boot)
    || (!st_q.vec_sel && boot_side_boot_lock && executing_boot);

  // Register port, flags, vector move guard and request gating
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = RST_REG;
    if (io_re)
    begin
      case (io_addr)
        OFS_MCU_CONTROL: st_d.rdata = 8'({st_q.vec_sel, st_q.vec_ce});
        OFS_SENSE_CONTROL: st_d.rdata = 8'(st_q.sense);
        OFS_EXT_MASK: st_d.rdata = 8'(st_q.emask);
        OFS_EXT_FLAG: st_d.rdata = 8'(st_q.eflag);
        OFS_PC_CONTROL: st_d.rdata = 8'(st_q.pcie);
        OFS_PC_FLAG: st_d.rdata = 8'(st_q.pcflag);
        default:
        begin
          for (int g = 0; g < PC_GROUPS; g++)
          begin
            if (io_addr == OFS_PC_MASK_BASE + 8'(g))
            begin
              st_d.rdata = st_q.pcmsk[g*PC_W +: PC_W];
            end
          end
        end
      endcase
    end
    if (io_we)
    begin
      if (io_addr == OFS_SENSE_CONTROL)
      begin
        st_d.sense = io_wdata[5:0];
      end
      if (io_addr == OFS_EXT_MASK)
      begin
        st_d.emask = io_wdata[EXT_N-1:0];
      end
      if (io_addr == OFS_PC_CONTROL)
      begin
        st_d.pcie = io_wdata[PC_GROUPS-1:0];
      end
      for (int g = 0; g < PC_GROUPS; g++)
      begin
        if (io_addr == OFS_PC_MASK_BASE + 8'(g))
        begin
          st_d.pcmsk[g*PC_W +: PC_W] = io_wdata;
        end
      end
    end
    if (st_q.vec_ce)
    begin
      st_d.ce_cnt = st_q.ce_cnt - 2'h1;
      if (st_q.ce_cnt == 2'h0)
      begin
        st_d.vec_ce = 1'b0;
      end
    end
    if (instr_done)
    begin
      st_d.post_blk = 1'b0;
    end
    if (mcu_wr)
    begin
      if (io_wdata[BIT_VEC_CE])
      begin
        st_d.vec_ce = 1'b1;
        st_d.ce_cnt = VEC_CE_LOAD;
      end
      else if (st_q.vec_ce)
      begin
        st_d.vec_sel = io_wdata[BIT_VEC_SEL];
        st_d.vec_ce = 1'b0;
        st_d.post_blk = 1'b1;
      end
    end
    // set beats clear, level mode forces zero
    for (int i = 0; i < EXT_N; i++)
    begin
      if (e_low[i])
      begin
        st_d.eflag[i] = 1'b0;
      end
      else if (e_set[i])
      begin
        st_d.eflag[i] = 1'b1;
      end
      else if (ext_ack[i] || (io_we && io_addr == OFS_EXT_FLAG
        && io_wdata[i]))
      begin
        st_d.eflag[i] = 1'b0;
      end
    end
    // Pin change group flags, set beats clear
    for (int g = 0; g < PC_GROUPS; g++)
    begin
      if (pc_hit[g])
      begin
        st_d.pcflag[g] = 1'b1;
      end
      else if (pc_ack[g] || (io_we && io_addr == OFS_PC_FLAG
        && io_wdata[g]))
      begin
        st_d.pcflag[g] = 1'b0;
      end
    end
    st_d.blocked = st_d.vec_ce || st_d.post_blk;
    // no latch of a vanished level
    for (int i = 0; i < EXT_N; i++)
    begin
      st_d.ereq[i] = global_irq_enable && st_q.emask[i] && !st_d.blocked
        && !lock_sup && (e_low[i] ? !e_lvl[i] : st_d.eflag[i]);
    end
    st_d.pcreq = (global_irq_enable && !st_d.blocked && !lock_sup)
      ? (st_q.pcie & st_d.pcflag) : '0;
    st_d.vbase = st_d.vec_sel
      ? FLASH_WORDS - (BOOT_MIN_WORDS << (2'h3 - boot_size_fuses))
      : 16'h0000;
  end

  always_ff @(posedge clk or negedge rst_i_n)
  begin
    if (!rst_i_n)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // edges need the clock, so only levels and toggles wake
  assign wake_req = (|(~ext_irq_pin & e_low & st_q.emask))
    || (|((pin_change_input ^ p_lvl) & st_q.pcmsk));

  // Registered outputs
  assign io_rdata = st_q.rdata;
  assign ext_irq_req = st_q.ereq;
  assign pin_change_req = st_q.pcreq;
  assign vector_table_select = st_q.vec_sel;
  assign vector_base = st_q.vbase;
  assign irq_blocked = st_q.blocked;

  sequence s_ce_set;
    $rose(st_q.vec_ce);
  endsequence

  sequence s_ce_idle;
    (!mcu_wr)[*4];
  endsequence

  property p_ce_expire;
    @(posedge clk) disable iff (!rst_i_n)
    s_ce_set ##0 s_ce_idle |=> !st_q.vec_ce;
  endproperty
  a_ce_expire: assert property (p_ce_expire) else $error("ce not cleared");

  property p_ce_hold;
    @(posedge clk) disable iff (!rst_i_n)
    s_ce_set ##0 s_ce_idle |-> st_q.vec_ce && st_q.blocked;
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("ce window short");

  property p_block_req;
    @(posedge clk) disable iff (!rst_i_n)
    st_q.vec_ce |-> st_q.ereq == '0 && st_q.pcreq == '0;
  endproperty
  a_block_req: assert property (p_block_req) else $error("req in move");

  property p_sel_guard;
    @(posedge clk) disable iff (!rst_i_n)
    $changed(st_q.vec_sel) |-> $past(st_q.vec_ce) && st_q.post_blk;
  endproperty
  a_sel_guard: assert property (p_sel_guard) else $error("select unguarded");

  property p_base_zero;
    @(posedge clk) disable iff (!rst_i_n)
    !st_q.vec_sel |-> st_q.vbase == 16'h0000;
  endproperty
  a_base_zero: assert property (p_base_zero) else $error("base not zero");

  property p_level_req;
    @(posedge clk) disable iff (!rst_i_n)
    e_low[0] && !e_lvl[0] && st_q.emask[0] && global_irq_enable
      && !st_d.blocked && !lock_sup |=> st_q.ereq[0];
  endproperty
  a_level_req: assert property (p_level_req) else $error("level lost");

  property p_level_noflag;
    @(posedge clk) disable iff (!rst_i_n)
    e_low != '0 |=> (st_q.eflag & $past(e_low)) == '0;
  endproperty
  a_level_noflag: assert property (p_level_noflag) else $error("flag in lvl");

  property p_rise_flag;
    @(posedge clk) disable iff (!rst_i_n)
    e_rise[0] && st_q.sense[SENSE_LSB_0 +: SENSE_W] == SENSE_RISE
      |=> st_q.eflag[0] ##1 (st_q.eflag[0] || $past(ext_ack[0] || io_we));
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("edge missed");

  property p_gate;
    @(posedge clk) disable iff (!rst_i_n)
    st_q.ereq != '0 |-> $past(global_irq_enable)
      && (st_q.ereq & ~$past(st_q.emask)) == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("ungated request");

  property p_pc_flag;
    @(posedge clk) disable iff (!rst_i_n)
    pc_hit != '0 |=> (st_q.pcflag & $past(pc_hit)) == $past(pc_hit);
  endproperty
  a_pc_flag: assert property (p_pc_flag) else $error("pc toggle lost");

  property p_lock;
    @(posedge clk) disable iff (!rst_i_n)
    lock_sup |=> st_q.ereq == '0 && st_q.pcreq == '0;
  endproperty
  a_lock: assert property (p_lock) else $error("lock not honoured");

endmodule
`default_nettype wire

// ==== sim/pin_source.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
  parameter int SETTLE = 6
) (
  // Clock
  input wire logic clk,
  // Pins toward the controller
  output logic [2:0] ext_irq_pin,
  output logic [31:0] pin_change_input
);
  // Pins idle high, as pulled-up lines do
  initial
  begin
    ext_irq_pin = 3'h7;
    pin_change_input = 32'hFFFF_FFFF;
  end
  // held past sampling
  // Drive one dedicated pin, then hold it well past one instruction
  task automatic drive_ext(input int idx, input logic val);
    @(posedge clk);
    ext_irq_pin[idx] <= val;
    repeat (SETTLE) @(posedge clk);
    #1;
  endtask
  // flip a pin-change input, return before it is sampled
  task automatic flip_pc(input int idx);
    @(posedge clk);
    pin_change_input[idx] <= ~pin_change_input[idx];
    #1;
  endtask
  // Toggle one pin-change input and hold the new level
  task automatic toggle_pc(input int idx);
    @(posedge clk);
    pin_change_input[idx] <= ~pin_change_input[idx];
    repeat (SETTLE) @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ext_irq_pkg::*;
  localparam int LIMIT = 3000;
  logic clk;
  logic rst_n;
  logic [7:0] io_addr;
  logic [7:0] io_wdata;
  logic io_we;
  logic io_re;
  logic [7:0] io_rdata;
  logic global_irq_enable;
  logic instr_done;
  logic executing_boot;
  logic app_side_boot_lock;
  logic boot_side_boot_lock;
  logic [1:0] boot_size_fuses;
  logic [2:0] ext_ack;
  logic [3:0] pc_ack;
  logic [2:0] ext_irq_pin;
  logic [31:0] pin_change_input;
  logic [2:0] ext_irq_req;
  logic [3:0] pin_change_req;
  logic vector_table_select;
  logic [15:0] vector_base;
  logic irq_blocked;
  logic wake_req;
  int err_total;
  int checked;
  int cycles;
  logic [3:0] exp_lo;
  logic [3:0] exp_hi;
  logic [15:0] boot_base;
  // Design under test and the pin sources
  external_irq_sense_vector_ctl #(
    .FLASH_WORDS(16'h2000),
    .BOOT_MIN_WORDS(16'h0100)
  ) DUT (
    .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_we(io_we), .io_re(io_re), .io_rdata(io_rdata),
    .global_irq_enable(global_irq_enable), .instr_done(instr_done),
    .executing_boot(executing_boot),
    .app_side_boot_lock(app_side_boot_lock),
    .boot_side_boot_lock(boot_side_boot_lock),
    .boot_size_fuses(boot_size_fuses), .ext_ack(ext_ack), .pc_ack(pc_ack),
    .ext_irq_pin(ext_irq_pin), .pin_change_input(pin_change_input),
    .ext_irq_req(ext_irq_req), .pin_change_req(pin_change_req),
    .vector_table_select(vector_table_select), .vector_base(vector_base),
    .irq_blocked(irq_blocked), .wake_req(wake_req)
  );
  pin_source src (
    .clk(clk), .ext_irq_pin(ext_irq_pin),
    .pin_change_input(pin_change_input)
  );
  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      err_total = err_total + 1;
      conclude();
    end
  end
  task automatic conclude();
    if (err_total == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checked = checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    io_addr <= a;
    io_wdata <= d;
    io_we <= 1'b1;
    @(posedge clk);
    io_we <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge clk);
    io_addr <= a;
    io_re <= 1'b1;
    @(posedge clk);
    io_re <= 1'b0;
    #1;
    chk(nm, {8'h00, io_rdata}, {8'h00, exp});
  endtask
  task automatic pulse(input logic [2:0] e, input logic [3:0] p,
                       input logic idone);
    @(posedge clk);
    ext_ack <= e;
    pc_ack <= p;
    instr_done <= idone;
    @(posedge clk);
    ext_ack <= 3'h0;
    pc_ack <= 4'h0;
    instr_done <= 1'b0;
    wait_cyc(2);
  endtask
  task automatic ctx(input logic eb, input logic al, input logic bl);
    @(posedge clk);
    executing_boot <= eb;
    app_side_boot_lock <= al;
    boot_side_boot_lock <= bl;
    wait_cyc(3);
  endtask
  // Main sequence
  initial
  begin
    err_total = 0;
    checked = 0;
    cycles = 0;
    rst_n = 1'b0;
    io_addr = 8'h00;
    io_wdata = 8'h00;
    io_we = 1'b0;
    io_re = 1'b0;
    global_irq_enable = 1'b0;
    instr_done = 1'b0;
    executing_boot = 1'b0;
    app_side_boot_lock = 1'b0;
    boot_side_boot_lock = 1'b0;
    boot_size_fuses = 2'h1;
    ext_ack = 3'h0;
    pc_ack = 4'h0;
    exp_lo = 4'h7;
    exp_hi = 4'hA;
    boot_base = 16'h2000 - (16'h0100 << (3 - 1));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(4);
    rd_chk("ctl_rst", OFS_MCU_CONTROL, 8'h00);
    rd_chk("sense_rst", OFS_SENSE_CONTROL, 8'h00);
    rd_chk("mask_rst", OFS_EXT_MASK, 8'h00);
    rd_chk("unmapped", 8'h7F, 8'h00);
    wr(OFS_SENSE_CONTROL, 8'h39);
    rd_chk("sense_rw", OFS_SENSE_CONTROL, 8'h39);
    // Every sense code on pin 0, falling then rising
    global_irq_enable <= 1'b1;
    wr(OFS_EXT_MASK, 8'h07);
    for (int m = 0; m < 4; m++)
    begin
      wr(OFS_SENSE_CONTROL, 8'(m));
      wr(OFS_EXT_FLAG, 8'h07);
      src.drive_ext(0, 1'b0);
      chk("req_fall", 16'(ext_irq_req), 16'(exp_lo[m]));
      pulse(3'h1, 4'h0, 1'b0);
      src.drive_ext(0, 1'b1);
      chk("req_rise", 16'(ext_irq_req), 16'(exp_hi[m]));
      pulse(3'h1, 4'h0, 1'b0);
    end
    // Interrupt 2 field at bits 5:4
    wr(OFS_SENSE_CONTROL, 8'h20);
    src.drive_ext(2, 1'b0);
    chk("req_pin2", 16'(ext_irq_req), 16'h0004);
    pulse(3'h4, 4'h0, 1'b0);
    src.drive_ext(2, 1'b1);
    // Global enable gates the request, not the flag
    global_irq_enable <= 1'b0;
    wr(OFS_SENSE_CONTROL, 8'h02);
    src.drive_ext(0, 1'b0);
    chk("req_gie0", 16'(ext_irq_req), 16'h0000);
    chk("wake_edge", 16'(wake_req), 16'h0000);
    rd_chk("flag_set", OFS_EXT_FLAG, 8'h01);
    global_irq_enable <= 1'b1;
    wait_cyc(3);
    chk("req_gie1", 16'(ext_irq_req), 16'h0001);
    wr(OFS_EXT_FLAG, 8'h01);
    wait_cyc(2);
    chk("req_w1c", 16'(ext_irq_req), 16'h0000);
    src.drive_ext(0, 1'b1);
    // Pin-change groups with per-pin masks
    wr(OFS_PC_CONTROL, 8'h0F);
    wr(OFS_PC_MASK_BASE + 8'h03, 8'h80);
    src.toggle_pc(31);
    chk("pc_req3", 16'(pin_change_req), 16'h0008);
    rd_chk("pc_flag3", OFS_PC_FLAG, 8'h08);
    pulse(3'h0, 4'h8, 1'b0);
    src.toggle_pc(30);
    chk("pc_unmasked", 16'(pin_change_req), 16'h0000);
    wr(OFS_PC_MASK_BASE, 8'h01);
    src.toggle_pc(0);
    chk("pc_req0", 16'(pin_change_req), 16'h0001);
    src.flip_pc(0);
    chk("wake_pc", 16'(wake_req), 16'h0001);
    wait_cyc(3);
    chk("wake_pc_end", 16'(wake_req), 16'h0000);
    // Level request pending during the vector move
    wr(OFS_SENSE_CONTROL, 8'h00);
    wr(OFS_EXT_MASK, 8'h01);
    src.drive_ext(0, 1'b0);
    chk("level_req", 16'(ext_irq_req), 16'h0001);
    chk("wake_lvl", 16'(wake_req), 16'h0001);
    wr(OFS_MCU_CONTROL, 8'h01);
    chk("blocked_ce", 16'(irq_blocked), 16'h0001);
    wr(OFS_MCU_CONTROL, 8'h02);
    wait_cyc(3);
    chk("blocked_hold", 16'(irq_blocked), 16'h0001);
    chk("req_blocked", 16'(ext_irq_req), 16'h0000);
    chk("select", 16'(vector_table_select), 16'h0001);
    chk("base_boot", vector_base, boot_base);
    rd_chk("ce_cleared", OFS_MCU_CONTROL, 8'h02);
    pulse(3'h0, 4'h0, 1'b1);
    chk("unblocked", 16'(irq_blocked), 16'h0000);
    // Window left to lapse
    wr(OFS_MCU_CONTROL, 8'h01);
    wait_cyc(2);
    chk("lapse_hold", 16'(irq_blocked), 16'h0001);
    wait_cyc(4);
    chk("lapse_end", 16'(irq_blocked), 16'h0000);
    rd_chk("ce_lapsed", OFS_MCU_CONTROL, 8'h02);
    wr(OFS_MCU_CONTROL, 8'h00);
    rd_chk("sel_guarded", OFS_MCU_CONTROL, 8'h02);
    // Lock suppression, vectors in boot
    ctx(1'b0, 1'b1, 1'b0);
    chk("lock_app", 16'(ext_irq_req), 16'h0000);
    ctx(1'b1, 1'b1, 1'b0);
    chk("lock_app_off", 16'(ext_irq_req), 16'h0001);
    // Move back to flash start, then boot-side lock
    wr(OFS_MCU_CONTROL, 8'h01);
    wr(OFS_MCU_CONTROL, 8'h00);
    pulse(3'h0, 4'h0, 1'b1);
    chk("base_flash", vector_base, 16'h0000);
    chk("select_flash", 16'(vector_table_select), 16'h0000);
    ctx(1'b1, 1'b0, 1'b1);
    chk("lock_boot", 16'(ext_irq_req), 16'h0000);
    ctx(1'b0, 1'b0, 1'b1);
    chk("lock_boot_off", 16'(ext_irq_req), 16'h0001);
    src.drive_ext(0, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
